// ===== dual_rail_power_sequencer.v
// Contract
// - boost starts first, then requested rail
// - boost off when both enables low or lockout
// - soft start fixed on-time below 1.2V, else valley
// - wait 60us after power-good before rails
// - positive regulator ramps over 500us
// - charge pump current limit follows mode bit
// - bits 4/3 enable negative/positive, reset off
// - write guard protects rail-enable bits
// - register enables also start the boost
// - each enable low stops only its own rail
// - discharge selected rail during power-down
// - setpoints 4V to 6V, 100mV steps, 5.4V default
// - boost target is larger setpoint plus margin
// - skip switching at zero current until below regulation; code skips only while boost_rail_low_i is high
// - lockout below 2.2V until input reaches 2.4V
// - registers survive lockout, reset only at power-on
// - stop switching on overvoltage until it clears
// - short below 1.2V gives discontinuous boost operation
// - limit register bit 4 selects regulator limit
// - zero selects 370mA, one selects 270mA
// - positive overload held 32ms shuts device down
// - negative current limit follows current mode
// - mode bit zero is 80mA and default
// - thermal shutdown, restart through full soft start
`timescale 1ns/100ps
`default_nettype none
`include "dual_rail_power_sequencer_map.vh"

module dual_rail_power_sequencer #(
   parameter [7:0] GUARD_UNLOCK = `WRITE_GUARD_UNLOCK,
   parameter integer POS_RAMP_CYC = `POS_RAMP_CYC,
   parameter integer OVERLOAD_CYC = `OVERLOAD_CYC
) (
   // clock and power-on reset
   input wire clk_i,
   input wire reset_n_i,
   // enable pins
   input wire pos_rail_enable_i,
   input wire neg_rail_enable_i,
   // serial register port
   input wire scl_i,
   input wire sda_i,
   output wire sda_o,
   output wire sda_oe_o,
   // analog comparators
   input wire uvlo_i,
   input wire boost_pg_i,
   input wire boost_rail_low_i,
   input wire boost_ovp_i,
   input wire zero_current_i,
   input wire below_regulation_i,
   input wire pos_overload_i,
   input wire thermal_i,
   // boost stage
   output reg boost_en_o,
   output reg [1:0] boost_mode_o,
   output reg boost_switch_o,
   output reg [5:0] boost_target_o,
   // positive regulator
   output reg pos_ldo_en_o,
   output reg pos_ramp_active_o,
   output reg pos_limit_sel_o,
   output reg pos_discharge_o,
   output reg [4:0] pos_setpoint_o,
   // negative charge pump
   output reg neg_cp_en_o,
   output reg neg_current_mode_o,
   output reg neg_discharge_o,
   output reg [4:0] neg_setpoint_o,
   // status
   output reg overload_shutdown_o
);
   localparam ST_OFF = 2'd0;
   localparam ST_SOFT = 2'd1;
   localparam ST_PG_WAIT = 2'd2;
   localparam ST_RUN = 2'd3;
   localparam integer PG_DELAY_INT = `PG_DELAY_CYC;
   localparam [11:0] PG_DELAY = PG_DELAY_INT[11:0];

   function [4:0] clamp_code;
      input [4:0] code;
      begin
         clamp_code = (code > `SETPOINT_MAX_CODE) ? `SETPOINT_MAX_CODE : code;
      end
   endfunction

   reg [4:0] pos_set_r;
   reg [4:0] neg_set_r;
   reg [7:0] app_r;
   reg [7:0] limit_r;
   reg [7:0] guard_r;
   reg [1:0] state_r;
   reg [11:0] pg_cnt_r;
   reg [31:0] ramp_cnt_r;
   reg [31:0] ovl_cnt_r;
   reg skip_r;
   reg [7:0] rdata;

   wire [7:0] bus_addr;
   wire [7:0] bus_wdata;
   wire bus_wr;

   i2c_reg_port u_port (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .addr_o(bus_addr),
      .wdata_o(bus_wdata),
      .wr_stb_o(bus_wr),
      .rdata_i(rdata)
   );

   // registers see only power-on reset; lockout never clears them
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         pos_set_r <= `SETPOINT_RESET;
         neg_set_r <= `SETPOINT_RESET;
         app_r <= `APP_CONTROL_RESET;
         limit_r <= `LIMIT_CONTROL_RESET;
         guard_r <= `WRITE_GUARD_RESET;
      end else if (bus_wr) begin
         case (bus_addr)
            `POS_SETPOINT_ADDR: pos_set_r <= clamp_code(bus_wdata[4:0]);
            `NEG_SETPOINT_ADDR: neg_set_r <= clamp_code(bus_wdata[4:0]);
            `APP_CONTROL_ADDR: begin
               // enable bits only move while the guard holds the unlock value
               if (guard_r == GUARD_UNLOCK)
                  app_r <= bus_wdata & `APP_WRITABLE_MASK;
               else
                  app_r <= (bus_wdata & `APP_WRITABLE_MASK & ~`APP_ENABLE_MASK)
                     | (app_r & `APP_ENABLE_MASK);
            end
            `LIMIT_CONTROL_ADDR: limit_r <= bus_wdata & `LIMIT_WRITABLE_MASK;
            `WRITE_GUARD_ADDR: guard_r <= bus_wdata;
            default: ;
         endcase
      end
   end

   always @* begin
      case (bus_addr)
         `POS_SETPOINT_ADDR: rdata = {3'b000, pos_set_r};
         `NEG_SETPOINT_ADDR: rdata = {3'b000, neg_set_r};
         `APP_CONTROL_ADDR: rdata = app_r;
         `LIMIT_CONTROL_ADDR: rdata = limit_r;
         `WRITE_GUARD_ADDR: rdata = guard_r;
         default: rdata = 8'h00;
      endcase
   end

   // pin and register enables combine
   wire pos_req = pos_rail_enable_i | app_r[`APP_POS_ENABLE_BIT];
   wire neg_req = neg_rail_enable_i | app_r[`APP_NEG_ENABLE_BIT];
   wire any_req = pos_req | neg_req;
   // lockout hysteresis lives in the comparator; uvlo_i is its output
   wire shutdown = uvlo_i | thermal_i | overload_shutdown_o;
   wire mode_150 = app_r[`APP_CURRENT_MODE_BIT];

   wire [4:0] max_set = (pos_set_r > neg_set_r) ? pos_set_r : neg_set_r;
   wire [5:0] margin = mode_150 ? `BOOST_MARGIN_150MA : `BOOST_MARGIN_80MA;

   reg [1:0] state_nxt;
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF: begin
            if (any_req && !shutdown)
               state_nxt = ST_SOFT;
         end
         ST_SOFT: begin
            if (boost_pg_i)
               state_nxt = ST_PG_WAIT;
         end
         ST_PG_WAIT: begin
            if (pg_cnt_r == PG_DELAY - 12'd1)
               state_nxt = ST_RUN;
         end
         ST_RUN: state_nxt = ST_RUN;
         default: state_nxt = ST_OFF;
      endcase
      // thermal recovery re-enters through full soft start
      if (!any_req || shutdown)
         state_nxt = ST_OFF;
   end

   wire run_nxt = (state_nxt == ST_RUN) && boost_pg_i;
   wire ldo_nxt = run_nxt && pos_req;
   wire cp_nxt = run_nxt && neg_req;
   wire boost_nxt = state_nxt != ST_OFF;
   // fixed on-time and runt-rail modes are both discontinuous
   wire dcm_nxt = boost_nxt && boost_rail_low_i;

   reg [1:0] mode_nxt;
   always @* begin
      case (state_nxt)
         ST_OFF: mode_nxt = `BOOST_MODE_OFF;
         ST_SOFT: mode_nxt = boost_rail_low_i ? `BOOST_MODE_FIXED_ON
            : `BOOST_MODE_VALLEY;
         default: mode_nxt = boost_rail_low_i ? `BOOST_MODE_FIXED_ON
            : `BOOST_MODE_NORMAL;
      endcase
   end

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= ST_OFF;
         pg_cnt_r <= 12'd0;
      end else begin
         state_r <= state_nxt;
         pg_cnt_r <= (state_nxt == ST_PG_WAIT && state_r == ST_PG_WAIT)
            ? pg_cnt_r + 12'd1 : 12'd0;
      end
   end

   // zero current ends a cycle; a sagging rail restarts switching
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         skip_r <= 1'b0;
      end else if (!dcm_nxt || below_regulation_i) begin
         skip_r <= 1'b0;
      end else if (zero_current_i) begin
         skip_r <= 1'b1;
      end
   end

   // ramp restarts whenever the regulator is switched on
   always @(posedge clk_i) begin
      if (!reset_n_i || !ldo_nxt) begin
         ramp_cnt_r <= 32'd0;
      end else if (ramp_cnt_r != POS_RAMP_CYC) begin
         ramp_cnt_r <= ramp_cnt_r + 32'd1;
      end
   end

   // overload shutdown holds until both enables drop; a fresh trip wins
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         ovl_cnt_r <= 32'd0;
         overload_shutdown_o <= 1'b0;
      end else begin
         if (pos_ldo_en_o && pos_overload_i) begin
            if (ovl_cnt_r != OVERLOAD_CYC)
               ovl_cnt_r <= ovl_cnt_r + 32'd1;
         end else begin
            ovl_cnt_r <= 32'd0;
         end
         if (ovl_cnt_r == OVERLOAD_CYC - 1)
            overload_shutdown_o <= 1'b1;
         else if (!any_req)
            overload_shutdown_o <= 1'b0;
      end
   end

   // registered copies keep the power-stage controls glitch free
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         pos_limit_sel_o <= 1'b0;
         neg_current_mode_o <= 1'b0;
         pos_setpoint_o <= `SETPOINT_RESET;
         neg_setpoint_o <= `SETPOINT_RESET;
      end else begin
         pos_limit_sel_o <= limit_r[`LIMIT_POS_SELECT_BIT];
         neg_current_mode_o <= mode_150;
         pos_setpoint_o <= pos_set_r;
         neg_setpoint_o <= neg_set_r;
      end
   end

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         boost_en_o <= 1'b0;
         boost_mode_o <= `BOOST_MODE_OFF;
         boost_switch_o <= 1'b0;
         boost_target_o <= 6'd0;
      end else begin
         boost_en_o <= boost_nxt;
         boost_mode_o <= mode_nxt;
         boost_switch_o <= boost_nxt && !boost_ovp_i
            && !(skip_r && dcm_nxt);
         boost_target_o <= {1'b0, max_set} + margin;
      end
   end

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         pos_ldo_en_o <= 1'b0;
         pos_ramp_active_o <= 1'b0;
         pos_discharge_o <= 1'b0;
         neg_cp_en_o <= 1'b0;
         neg_discharge_o <= 1'b0;
      end else begin
         pos_ldo_en_o <= ldo_nxt;
         neg_cp_en_o <= cp_nxt;
         pos_ramp_active_o <= ldo_nxt && ramp_cnt_r != POS_RAMP_CYC;
         // discharge only on power-down by enable low or lockout
         pos_discharge_o <= app_r[`APP_POS_DISCHARGE_BIT] && !ldo_nxt
            && (!pos_req || uvlo_i);
         neg_discharge_o <= app_r[`APP_NEG_DISCHARGE_BIT] && !cp_nxt
            && (!neg_req || uvlo_i);
      end
   end
endmodule

`default_nettype wire

// ===== dual_rail_power_sequencer_map.vh
`ifndef DUAL_RAIL_POWER_SEQUENCER_MAP_VH
`define DUAL_RAIL_POWER_SEQUENCER_MAP_VH

// clock
`define CLK_PERIOD_NS 20

// register offsets (8-bit register pointer)
`define POS_SETPOINT_ADDR 8'h00
`define NEG_SETPOINT_ADDR 8'h01
`define APP_CONTROL_ADDR 8'h03
`define LIMIT_CONTROL_ADDR 8'h04
`define WRITE_GUARD_ADDR 8'h21

// reset values
`define SETPOINT_RESET 5'h0E
`define APP_CONTROL_RESET 8'h03
`define LIMIT_CONTROL_RESET 8'h01
`define WRITE_GUARD_RESET 8'h00
`define WRITE_GUARD_UNLOCK 8'h5A

// app_control_reg fields
`define APP_NEG_DISCHARGE_BIT 0
`define APP_POS_DISCHARGE_BIT 1
`define APP_POS_ENABLE_BIT 3
`define APP_NEG_ENABLE_BIT 4
`define APP_SOFT_RESET_BIT 5
`define APP_CURRENT_MODE_BIT 6
`define APP_WRITABLE_MASK 8'h7B
`define APP_ENABLE_MASK 8'h18

// limit_control_reg fields
`define LIMIT_POS_SELECT_BIT 4
`define LIMIT_WRITABLE_MASK 8'h13

// setpoint coding: 4.0V plus 100mV per step
`define SETPOINT_MAX_CODE 5'd20
`define BOOST_MARGIN_80MA 6'd2
`define BOOST_MARGIN_150MA 6'd4

// boost operating modes
`define BOOST_MODE_OFF 2'd0
`define BOOST_MODE_FIXED_ON 2'd1
`define BOOST_MODE_VALLEY 2'd2
`define BOOST_MODE_NORMAL 2'd3

// timing
`define PG_DELAY_NS 60000
`define PG_DELAY_CYC ((`PG_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POS_RAMP_NS 500000
`define POS_RAMP_CYC ((`POS_RAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OVERLOAD_NS 32000000
`define OVERLOAD_CYC ((`OVERLOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// i2c
`define I2C_DEV_ADDR 7'h3E

`endif

// ===== i2c_reg_port.v
`timescale 1ns/100ps
`default_nettype none
`include "dual_rail_power_sequencer_map.vh"

module i2c_reg_port (
   // clock and power-on reset
   input wire clk_i,
   input wire reset_n_i,
   // serial pins
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   // register side
   output reg [7:0] addr_o,
   output reg [7:0] wdata_o,
   output reg wr_stb_o,
   input wire [7:0] rdata_i
);
   localparam ST_IDLE = 3'd0;
   localparam ST_DEV = 3'd1;
   localparam ST_PTR = 3'd2;
   localparam ST_WR = 3'd3;
   localparam ST_RD = 3'd4;

   reg [2:0] state_r;
   reg scl_q_r;
   reg sda_q_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg ack_r;
   reg read_r;
   reg nack_r;

   wire scl_rise = scl_i & ~scl_q_r;
   wire scl_fall = ~scl_i & scl_q_r;
   wire start_cond = scl_i & scl_q_r & sda_q_r & ~sda_i;
   wire stop_cond = scl_i & scl_q_r & ~sda_q_r & sda_i;

   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_r <= ST_IDLE;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         bit_cnt_r <= 4'd0;
         shift_r <= 8'h00;
         ack_r <= 1'b0;
         read_r <= 1'b0;
         nack_r <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         addr_o <= 8'h00;
         wdata_o <= 8'h00;
         wr_stb_o <= 1'b0;
      end else begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
         wr_stb_o <= 1'b0;
         // pointer advances the cycle after the write is taken
         if (wr_stb_o)
            addr_o <= addr_o + 8'd1;
         if (start_cond) begin
            state_r <= ST_DEV;
            bit_cnt_r <= 4'd0;
            ack_r <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (stop_cond) begin
            state_r <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end else if (state_r != ST_IDLE && scl_rise) begin
            if (state_r == ST_RD && ack_r) begin
               nack_r <= sda_i;
               if (!sda_i)
                  addr_o <= addr_o + 8'd1;
            end else if (state_r != ST_RD && !ack_r) begin
               shift_r <= {shift_r[6:0], sda_i};
               bit_cnt_r <= bit_cnt_r + 4'd1;
            end
         end else if (state_r != ST_IDLE && scl_fall) begin
            case (state_r)
               ST_RD: begin
                  if (ack_r) begin
                     ack_r <= 1'b0;
                     if (nack_r) begin
                        state_r <= ST_IDLE;
                     end else begin
                        shift_r <= rdata_i;
                        sda_oe_o <= ~rdata_i[7];
                        bit_cnt_r <= 4'd1;
                     end
                  end else if (bit_cnt_r == 4'd8) begin
                     sda_oe_o <= 1'b0;
                     ack_r <= 1'b1;
                  end else begin
                     sda_oe_o <= ~shift_r[3'd7 - bit_cnt_r[2:0]];
                     bit_cnt_r <= bit_cnt_r + 4'd1;
                  end
               end
               default: begin
                  if (ack_r) begin
                     ack_r <= 1'b0;
                     bit_cnt_r <= 4'd0;
                     if (state_r == ST_DEV && read_r) begin
                        state_r <= ST_RD;
                        shift_r <= rdata_i;
                        sda_oe_o <= ~rdata_i[7];
                        bit_cnt_r <= 4'd1;
                     end else begin
                        sda_oe_o <= 1'b0;
                        state_r <= (state_r == ST_DEV) ? ST_PTR : ST_WR;
                     end
                  end else if (bit_cnt_r == 4'd8) begin
                     if (state_r == ST_DEV && shift_r[7:1] != `I2C_DEV_ADDR) begin
                        state_r <= ST_IDLE;
                     end else begin
                        ack_r <= 1'b1;
                        sda_oe_o <= 1'b1;
                        if (state_r == ST_DEV)
                           read_r <= shift_r[0];
                        else if (state_r == ST_PTR)
                           addr_o <= shift_r;
                        else begin
                           wdata_o <= shift_r;
                           wr_stb_o <= 1'b1;
                        end
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule

`default_nettype wire

// ===== dual_rail_power_sequencer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module dual_rail_power_sequencer_asserts #(
   parameter integer POS_RAMP_CYC = 50,
   parameter integer OVERLOAD_CYC = 100
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // comparators
   input wire logic uvlo_i,
   input wire logic boost_pg_i,
   input wire logic boost_ovp_i,
   input wire logic pos_overload_i,
   input wire logic thermal_i,
   // power stage controls
   input wire logic boost_en_o,
   input wire logic boost_switch_o,
   input wire logic [5:0] boost_target_o,
   input wire logic pos_ldo_en_o,
   input wire logic pos_ramp_active_o,
   input wire logic pos_discharge_o,
   input wire logic [4:0] pos_setpoint_o,
   input wire logic neg_cp_en_o,
   input wire logic neg_current_mode_o,
   input wire logic [4:0] neg_setpoint_o,
   input wire logic overload_shutdown_o
);
   logic [11:0] pg_cnt;
   logic [15:0] ramp_cnt;
   logic [31:0] ovl_cnt;
   logic [4:0] top_sp;
   logic [5:0] target_exp;
   assign top_sp = (pos_setpoint_o > neg_setpoint_o) ? pos_setpoint_o : neg_setpoint_o;
   assign target_exp = {1'b0, top_sp} + (neg_current_mode_o ? 6'h04 : 6'h02);
   // saturate so a long run never wraps back under the delay figure
   always @(posedge clk_i) begin
      if (!reset_n_i) begin
         pg_cnt <= 12'h000;
         ramp_cnt <= 16'h0000;
         ovl_cnt <= 32'h0000_0000;
      end else begin
         pg_cnt <= !(boost_en_o && boost_pg_i) ? 12'h000 : pg_cnt + {11'h000, pg_cnt != 12'hFFF};
         ramp_cnt <= pos_ramp_active_o ? ramp_cnt + 16'h0001 : 16'h0000;
         ovl_cnt <= (pos_overload_i && pos_ldo_en_o) ? ovl_cnt + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   a_rails_need_boost: assert property ((pos_ldo_en_o || neg_cp_en_o) |-> boost_en_o)
      else $error("rail on without boost");
   a_pg_delay: assert property (($rose(pos_ldo_en_o) || $rose(neg_cp_en_o)) |-> pg_cnt >= 3000)
      else $error("rail on before power-good delay");
   a_uvlo_all_off: assert property (uvlo_i |=> !boost_en_o && !pos_ldo_en_o && !neg_cp_en_o)
      else $error("stage still on in lockout");
   a_ovp_stop: assert property (boost_ovp_i |=> !boost_switch_o)
      else $error("switching during overvoltage");
   a_thermal_off: assert property (thermal_i |=> !boost_en_o && !neg_cp_en_o)
      else $error("stage still on when hot");
   a_target_sum: assert property (boost_en_o && $stable(pos_setpoint_o) && $stable(neg_setpoint_o)
      && $stable(neg_current_mode_o) |-> boost_target_o == target_exp)
      else $error("boost target wrong");
   a_setpoint_range: assert property (pos_setpoint_o <= 5'd20 && neg_setpoint_o <= 5'd20)
      else $error("setpoint above top code");
   a_ramp_length: assert property ($fell(pos_ramp_active_o) && pos_ldo_en_o |->
      ramp_cnt == POS_RAMP_CYC)
      else $error("ramp length wrong");
   a_overload_hold: assert property ($rose(overload_shutdown_o) |-> ovl_cnt >= OVERLOAD_CYC - 1)
      else $error("overload shutdown too early");
   a_overload_stops: assert property (overload_shutdown_o |=> !pos_ldo_en_o && !boost_en_o)
      else $error("stage on after overload shutdown");
   a_discharge_off: assert property (pos_discharge_o |-> !pos_ldo_en_o)
      else $error("discharge while regulator on");
endmodule
bind dual_rail_power_sequencer dual_rail_power_sequencer_asserts #(.POS_RAMP_CYC(POS_RAMP_CYC),
   .OVERLOAD_CYC(OVERLOAD_CYC)) asserts_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .uvlo_i(uvlo_i),
   .boost_pg_i(boost_pg_i), .boost_ovp_i(boost_ovp_i), .pos_overload_i(pos_overload_i),
   .thermal_i(thermal_i), .boost_en_o(boost_en_o), .boost_switch_o(boost_switch_o),
   .boost_target_o(boost_target_o), .pos_ldo_en_o(pos_ldo_en_o),
   .pos_ramp_active_o(pos_ramp_active_o), .pos_discharge_o(pos_discharge_o),
   .pos_setpoint_o(pos_setpoint_o), .neg_cp_en_o(neg_cp_en_o),
   .neg_current_mode_o(neg_current_mode_o), .neg_setpoint_o(neg_setpoint_o),
   .overload_shutdown_o(overload_shutdown_o));
`default_nettype wire

// ===== power_stage_model.sv
`timescale 1ns/100ps
`default_nettype none
module power_stage_model #(
   parameter int PG_CYC = 10
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // controls from the sequencer, overload request from the test
   input wire logic boost_en_i,
   input wire logic pos_ldo_en_i,
   input wire logic overload_req_i,
   // comparator outputs
   output logic boost_pg_o,
   output logic boost_rail_low_o,
   output logic zero_current_o,
   output logic below_regulation_o,
   output logic pos_overload_o
);
   logic [7:0] level_r;
   logic [1:0] phase_r;
   // rail collapses when boost stops, so every enable is a cold start
   always @(posedge clk_i) begin
      phase_r <= reset_n_i ? phase_r + 2'b01 : 2'b00;
      if (!reset_n_i || !boost_en_i) begin
         level_r <= 8'h00;
      end else if (level_r != 8'hFF) begin
         level_r <= level_r + 8'h01;
      end
   end
   assign boost_pg_o = level_r >= 8'(PG_CYC);
   assign boost_rail_low_o = level_r < 8'h04;
   // light load: current hits zero, later the rail sags below regulation
   assign zero_current_o = boost_en_i && phase_r == 2'b01;
   assign below_regulation_o = boost_en_i && phase_r == 2'b11;
   assign pos_overload_o = overload_req_i && pos_ldo_en_i;
endmodule
`default_nettype wire

// ===== dual_rail_power_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module dual_rail_power_sequencer_test;
   // unlock value is arbitrary
   localparam logic [7:0] guard = 8'hA7;
   logic clk = 0, reset_n = 0, pos_en = 0, neg_en = 0, scl = 1, sda_m = 1;
   logic uvlo = 0, ovp = 0, thermal = 0, ovl_req = 0, obs_stb = 0;
   logic [7:0] obs = 8'h00, code;
   logic [31:0] seed = 32'h0000_0032;
   int err_total = 0, check_count = 0;
   string nq[$];
   logic [7:0] eq[$], rx_exp[0:4];
   wire sda_oe, pg, rail_low, zc, br, povl, boost_en, sw, ldo, ramp, lim, pdis, cp, cmode, ndis, ovl;
   wire [1:0] mode;
   wire [5:0] target;
   wire [4:0] psp, nsp;
   wire sda = sda_m & ~sda_oe;
   dual_rail_power_sequencer #(.GUARD_UNLOCK(guard), .POS_RAMP_CYC(50), .OVERLOAD_CYC(100))
      dual_rail_power_sequencer_i (.clk_i(clk), .reset_n_i(reset_n), .pos_rail_enable_i(pos_en),
      .neg_rail_enable_i(neg_en), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .uvlo_i(uvlo), .boost_pg_i(pg), .boost_rail_low_i(rail_low), .boost_ovp_i(ovp),
      .zero_current_i(zc), .below_regulation_i(br), .pos_overload_i(povl), .thermal_i(thermal),
      .boost_en_o(boost_en), .boost_mode_o(mode), .boost_switch_o(sw), .boost_target_o(target),
      .pos_ldo_en_o(ldo), .pos_ramp_active_o(ramp), .pos_limit_sel_o(lim),
      .pos_discharge_o(pdis), .pos_setpoint_o(psp), .neg_cp_en_o(cp),
      .neg_current_mode_o(cmode), .neg_discharge_o(ndis), .neg_setpoint_o(nsp),
      .overload_shutdown_o(ovl));
   power_stage_model power_stage_model_i (.clk_i(clk), .reset_n_i(reset_n), .boost_en_i(boost_en),
      .pos_ldo_en_i(ldo), .overload_req_i(ovl_req), .boost_pg_o(pg), .boost_rail_low_o(rail_low),
      .zero_current_o(zc), .below_regulation_o(br), .pos_overload_o(povl));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic flag(int k);
      case (k)
         0: flag = ldo;
         1: flag = cp;
         2: flag = ovl;
         default: flag = boost_en;
      endcase
   endfunction
   task final_report;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task check(string n, logic [7:0] s, logic [7:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   always @(posedge clk) begin
      if (obs_stb === 1'b1) check(nq.pop_front(), obs, eq.pop_front());
   end
   task probe(string n, logic [7:0] e, logic [7:0] s);
      nq.push_back(n);
      eq.push_back(e);
      obs <= s;
      obs_stb <= 1;
      @(posedge clk);
      obs_stb <= 0;
      @(posedge clk);
   endtask
   task tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task wait_on(int k, int lim);
      int i;
      i = 0;
      while (flag(k) !== 1'b1 && i < lim) begin
         @(posedge clk);
         i++;
      end
      if (i >= lim) begin
         err_total++;
         final_report;
      end
   endtask
   // serial phases held three cycles each so the port sees every level three times
   task bit_o(logic b);
      sda_m <= b;
      tick(3);
      scl <= 1;
      tick(3);
      scl <= 0;
   endtask
   task bit_i(output logic b);
      sda_m <= 1;
      tick(3);
      scl <= 1;
      tick(3);
      b = sda;
      scl <= 0;
   endtask
   task start;
      sda_m <= 1;
      tick(3);
      scl <= 1;
      tick(3);
      sda_m <= 0;
      tick(3);
      scl <= 0;
      tick(3);
   endtask
   task stop;
      sda_m <= 0;
      tick(3);
      scl <= 1;
      tick(3);
      sda_m <= 1;
      tick(3);
   endtask
   task tx(logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) bit_o(d[i]);
      bit_i(a);
      probe("ack", 8'h00, {7'h00, a});
   endtask
   task wr(logic [7:0] p, logic [7:0] d);
      start;
      tx(8'h7C);
      tx(p);
      tx(d);
      stop;
   endtask
   task rd(logic [7:0] p, int n);
      logic [7:0] v;
      start;
      tx(8'h7C);
      tx(p);
      start;
      tx(8'h7D);
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) bit_i(v[i]);
         bit_o(k == n - 1);
         probe("rdata", rx_exp[k], v);
      end
      stop;
   endtask
   initial begin
      tick(6);
      reset_n <= 1;
      tick(1);
      rx_exp = '{8'h0E, 8'h0E, 8'h00, 8'h03, 8'h01};
      rd(8'h00, 5);
      rx_exp[0] = 8'h00;
      rd(8'h21, 1);
      wr(8'h03, 8'h1B);
      rx_exp[0] = 8'h03;
      rd(8'h03, 1);
      probe("boost_en", 8'h00, {7'h00, boost_en});
      seed = xs(seed);
      code = 8'(seed % 21);
      wr(8'h00, code);
      wr(8'h01, 8'h1F);
      rx_exp[0] = code;
      rx_exp[1] = 8'h14;
      rd(8'h00, 2);
      probe("psp", code, {3'h0, psp});
      probe("nsp", 8'h14, {3'h0, nsp});
      wr(8'h21, guard);
      wr(8'h03, 8'h5B);
      rx_exp[0] = 8'h5B;
      rd(8'h03, 1);
      probe("boost_en", 8'h01, {7'h00, boost_en});
      probe("ldo_en", 8'h00, {7'h00, ldo});
      wait_on(0, 4000);
      tick(2);
      probe("ramp", 8'h01, {7'h00, ramp});
      probe("mode", 8'h03, {6'h00, mode});
      probe("cp_en", 8'h01, {7'h00, cp});
      probe("cmode", 8'h01, {7'h00, cmode});
      probe("target", 8'h18, {2'b00, target});
      wr(8'h03, 8'h53);
      probe("ldo_en", 8'h00, {7'h00, ldo});
      probe("cp_en", 8'h01, {7'h00, cp});
      probe("pos_dis", 8'h01, {7'h00, pdis});
      uvlo <= 1;
      tick(3);
      probe("boost_en", 8'h00, {7'h00, boost_en});
      probe("neg_dis", 8'h01, {7'h00, ndis});
      rx_exp[0] = 8'h53;
      rd(8'h03, 1);
      uvlo <= 0;
      wr(8'h03, 8'h00);
      wr(8'h04, 8'hF0);
      rx_exp[0] = 8'h10;
      rd(8'h04, 1);
      probe("lim_sel", 8'h01, {7'h00, lim});
      pos_en <= 1;
      wait_on(0, 4000);
      ovl_req <= 1;
      wait_on(2, 300);
      tick(3);
      probe("boost_en", 8'h00, {7'h00, boost_en});
      ovl_req <= 0;
      pos_en <= 0;
      tick(3);
      probe("ovl", 8'h00, {7'h00, ovl});
      neg_en <= 1;
      wait_on(1, 4000);
      ovp <= 1;
      tick(3);
      probe("switch", 8'h00, {7'h00, sw});
      ovp <= 0;
      thermal <= 1;
      tick(3);
      probe("boost_en", 8'h00, {7'h00, boost_en});
      thermal <= 0;
      wait_on(3, 10);
      probe("mode", 8'h01, {6'h00, mode});
      probe("cp_en", 8'h00, {7'h00, cp});
      wait_on(1, 4000);
      neg_en <= 0;
      tick(3);
      final_report;
   end
endmodule
`default_nettype wire
